// [uoe_pkg.sv]
// Package for the OUT endpoint 0 control block: offsets, fields, reset values and types.
package uoe_pkg;

  localparam logic [11:0] UOE_CTL_OFFSET      = 12'hb00;
  localparam logic [31:0] UOE_CTL_RESET       = 32'h0000_8000;
  localparam int          UOE_EN_BIT          = 31;
  localparam int          UOE_DIS_BIT         = 30;
  localparam int          UOE_NAK_SET_BIT     = 27;
  localparam int          UOE_NAK_CLR_BIT     = 26;
  localparam int          UOE_STALL_BIT       = 21;
  localparam int          UOE_SNOOP_BIT       = 20;
  localparam int          UOE_TYPE_LSB        = 18;
  localparam int          UOE_NAK_STAT_BIT    = 17;
  localparam int          UOE_ACTIVE_BIT      = 15;
  localparam logic [1:0]  UOE_TYPE_CONTROL    = 2'h0;
  localparam logic [1:0]  UOE_MPL_64          = 2'h0;
  localparam logic [1:0]  UOE_MPL_32          = 2'h1;

  typedef enum logic [1:0] {
    UOE_RSP_DATA  = 2'b00,
    UOE_RSP_NAK   = 2'b01,
    UOE_RSP_STALL = 2'b10
  } uoe_rsp_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } uoe_bus_t;

  typedef struct packed {
    logic       out_token;
    logic       setup_token;
    logic       global_out_nak;
    logic [1:0] in_ep0_mpl;
  } uoe_link_t;

endpackage : uoe_pkg

// [uoe_ctl.sv]
// OUT endpoint 0 control register and handshake selection logic.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Function
// (RQ1) Register resets to endpoint-active only
// (RQ2) Enable set by software, cleared by core
// (RQ3) Disable bit reads zero, writes ignored
// (RQ4) Set-NAK strobe sets NAK status
// (RQ5) Clear-NAK strobe clears NAK status
// (RQ6) Stall bit answers OUT with STALL
// (RQ7) SETUP token clears stall bit
// (RQ8) STALL outranks NAK
// (RQ9) Snoop bit skips data CRC check
// (RQ10) Transfer type always reads control
// (RQ11) Otherwise answer from receive FIFO state; the code always answers DATA here
// (RQ12) NAK status answers every OUT with NAK unless stall is set
// (RQ13) NAK status is read-only to software
// (RQ14) Endpoint active always reads one
// (RQ15) Length code mirrors IN endpoint 0
// (RQ16) Strobes and reserved bits read zero
// (RQ17) Codes 10 and 11 mirrored unchanged
module uoe_ctl
  import uoe_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  input  wire uoe_bus_t   bus_in,
  input  wire uoe_link_t  link_in,
  input  wire logic       ep_done_in,
  output logic [31:0]     rdata_out,
  output uoe_rsp_t        rsp_out,
  output logic            rsp_valid_out,
  output logic            crc_check_out,
  output logic            ep_enable_out
);

  // Bus decode is shared by the enable, stall, snoop, NAK and read-data groups below.
  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] wdata;

  always_comb
  begin
    if (bus_in.addr == UOE_CTL_OFFSET)
    begin
      hit = 1'b1;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  always_comb
  begin
    wr_hit = bus_in.wr && hit;
    rd_hit = bus_in.rd && hit;
    wdata  = bus_in.wdata;
  end

  // Enable: software may only set it, and a same-cycle set beats the done pulse.
  logic        en_r;
  logic        en_nxt;

  always_comb
  begin
    en_nxt = en_r;
    if (ep_done_in)
    begin
      en_nxt = 1'b0; // RQ2
    end
    if (wr_hit && wdata[UOE_EN_BIT])
    begin
      en_nxt = 1'b1; // RQ2
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      en_r <= UOE_CTL_RESET[UOE_EN_BIT]; // RQ1
    end
    else if (ce_in)
    begin
      en_r <= en_nxt;
    end
  end

  // Stall is set-only for software; the SETUP clear yields to a set in the same cycle.
  logic        stall_r;
  logic        stall_nxt;

  always_comb
  begin
    stall_nxt = stall_r;
    if (link_in.setup_token)
    begin
      stall_nxt = 1'b0; // RQ7
    end
    if (wr_hit && wdata[UOE_STALL_BIT])
    begin
      stall_nxt = 1'b1; // RQ6
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stall_r <= UOE_CTL_RESET[UOE_STALL_BIT]; // RQ1
    end
    else if (ce_in)
    begin
      stall_r <= stall_nxt;
    end
  end

  // The CRC enable has its own flop so that no inverter sits between register and pin.
  logic        snoop_r;
  logic        snoop_nxt;
  logic        crc_r;
  logic        crc_nxt;

  always_comb
  begin
    snoop_nxt = snoop_r;
    if (wr_hit)
    begin
      snoop_nxt = wdata[UOE_SNOOP_BIT]; // RQ9
    end
    crc_nxt = ~snoop_nxt; // RQ9
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      snoop_r <= UOE_CTL_RESET[UOE_SNOOP_BIT]; // RQ1
      crc_r   <= ~UOE_CTL_RESET[UOE_SNOOP_BIT];
    end
    else if (ce_in)
    begin
      snoop_r <= snoop_nxt;
      crc_r   <= crc_nxt;
    end
  end

  // Set wins if software writes both strobes in one word.
  logic        nak_r;
  logic        nak_nxt;

  always_comb
  begin
    nak_nxt = nak_r;
    if (wr_hit && wdata[UOE_NAK_CLR_BIT])
    begin
      nak_nxt = 1'b0; // RQ5 RQ13
    end
    if (wr_hit && wdata[UOE_NAK_SET_BIT])
    begin
      nak_nxt = 1'b1; // RQ4 RQ13
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      nak_r <= UOE_CTL_RESET[UOE_NAK_STAT_BIT]; // RQ1
    end
    else if (ce_in)
    begin
      nak_r <= nak_nxt;
    end
  end

  // The length code is sampled every enabled cycle; software writes never reach it.
  logic [1:0]  mpl_r;
  logic [1:0]  mpl_nxt;

  always_comb
  begin
    mpl_nxt = link_in.in_ep0_mpl; // RQ15 RQ17
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      mpl_r <= UOE_MPL_64;
    end
    else if (ce_in)
    begin
      mpl_r <= mpl_nxt;
    end
  end

  // Read data are zero except after an enabled read, and hold while ce_in is low, so a stale word only lingers with ce_in low.
  // Fixed fields are built here rather than stored, so no write can disturb them.
  logic [31:0] view;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb
  begin
    view = 32'h0000_0000; // RQ3 RQ16
    view[UOE_EN_BIT] = en_r;
    view[UOE_STALL_BIT] = stall_r;
    view[UOE_SNOOP_BIT] = snoop_r;
    view[UOE_TYPE_LSB +: 2] = UOE_TYPE_CONTROL; // RQ10
    view[UOE_NAK_STAT_BIT] = nak_r; // RQ13
    view[UOE_ACTIVE_BIT] = 1'b1; // RQ14
    view[1:0] = mpl_r; // RQ15
    rdata_nxt = 32'h0000_0000;
    if (rd_hit)
    begin
      rdata_nxt = view;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // The answer uses state from before this edge's writes, so a write affects the next token.
  uoe_rsp_t    rsp_r;
  uoe_rsp_t    rsp_nxt;

  always_comb
  begin
    rsp_nxt = rsp_r;
    if (link_in.out_token)
    begin
      if (stall_r)
      begin
        rsp_nxt = UOE_RSP_STALL; // RQ6 RQ8
      end
      else if (link_in.global_out_nak || nak_r)
      begin
        rsp_nxt = UOE_RSP_NAK; // RQ12
      end
      else
      begin
        rsp_nxt = UOE_RSP_DATA; // RQ11
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rsp_r <= UOE_RSP_DATA;
    end
    else if (ce_in)
    begin
      rsp_r <= rsp_nxt;
    end
  end

  // Valid marks the single cycle in which a new answer stands.
  logic        rspv_r;
  logic        rspv_nxt;

  always_comb
  begin
    rspv_nxt = link_in.out_token;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rspv_r <= 1'b0;
    end
    else if (ce_in)
    begin
      rspv_r <= rspv_nxt;
    end
  end

  // Every output is a register, so nothing combinational reaches the pins.
  assign rdata_out     = rdata_r;
  assign rsp_out       = rsp_r;
  assign rsp_valid_out = rspv_r;
  assign crc_check_out = crc_r; // RQ9
  assign ep_enable_out = en_r;

endmodule : uoe_ctl

`default_nettype wire

// [uoe_ctl_monitor.sv]
// Checker for the OUT endpoint 0 control block ports.
`timescale 1ns/10ps
`default_nettype none
module uoe_ctl_monitor
  import uoe_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  input wire logic        ep_done_in,
  input wire logic        rsp_valid_out,
  input wire logic        crc_check_out,
  input wire logic        ep_enable_out,
  input wire uoe_bus_t    bus_in,
  input wire uoe_link_t   link_in,
  input wire logic [31:0] rdata_out,
  input wire uoe_rsp_t    rsp_out
);
  wire rd = ce_in && bus_in.rd && bus_in.addr == UOE_CTL_OFFSET;
  wire wr = ce_in && bus_in.wr && bus_in.addr == UOE_CTL_OFFSET;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_fixed_bits: assert property (rd |=> rdata_out[30:22] == 9'h0 && rdata_out[19:18] == 2'h0 && rdata_out[16:2] == 15'h2000)
    else $error("fixed bits wrong");
  a_mpl_copy: assert property ($past(rstn_in) && $past(ce_in) && rd && $stable(link_in.in_ep0_mpl) |=> rdata_out[1:0] == $past(link_in.in_ep0_mpl))
    else $error("length code not mirrored");
  a_idle_zero: assert property (ce_in && !rd |=> rdata_out == 32'h0)
    else $error("read data not zero");
  a_en_set: assert property (wr && bus_in.wdata[31] |=> ep_enable_out)
    else $error("enable not set");
  a_en_keep: assert property (ce_in && ep_enable_out && !ep_done_in |=> ep_enable_out)
    else $error("enable lost");
  a_en_drop: assert property (ce_in && ep_done_in && !(wr && bus_in.wdata[31]) |=> !ep_enable_out)
    else $error("enable not cleared");
  a_snoop_crc: assert property (wr |=> crc_check_out == !$past(bus_in.wdata[20]))
    else $error("crc check wrong");
  a_rsp_time: assert property (ce_in |=> rsp_valid_out == $past(link_in.out_token))
    else $error("response timing wrong");
  a_gnak_rsp: assert property (ce_in && link_in.out_token && link_in.global_out_nak |=> rsp_out != UOE_RSP_DATA)
    else $error("global nak ignored");
endmodule : uoe_ctl_monitor
`default_nettype wire

// [uoe_host.sv]
// Host model issuing OUT and SETUP tokens to endpoint 0.
`timescale 1ns/10ps
`default_nettype none
module uoe_host
  import uoe_pkg::*;
(
  input  wire logic      clk_in,
  output var uoe_link_t  link_out
);
  logic [1:0] max_packet_length_code = 2'h0;
  initial link_out = '0;
  task send(input logic setup, gnak);
    @(posedge clk_in);
    link_out <= '{!setup, setup, gnak, max_packet_length_code};
    @(posedge clk_in);
    link_out <= '{1'b0, 1'b0, gnak, max_packet_length_code};
  endtask : send
  task set_mpl(input logic [1:0] m);
    @(posedge clk_in);
    max_packet_length_code = m;
    link_out <= '{1'b0, 1'b0, link_out.global_out_nak, m};
  endtask : set_mpl
endmodule : uoe_host
`default_nettype wire

// [uoe_ctl_bench.sv]
// Bench for the OUT endpoint 0 control block.
`timescale 1ns/10ps
`default_nettype none
module uoe_ctl_bench;
  import uoe_pkg::*;
  logic        clk_in = 0, rstn_in = 0, ce_in = 1, ep_done_in = 0, rsp_valid_out, crc_check_out, ep_enable_out;
  uoe_bus_t    bus_in = '0;
  uoe_link_t   link_in;
  logic [31:0] rdata_out;
  uoe_rsp_t    rsp_out;
  int          fails = 0, checks_done = 0;
  uoe_host u_uoe_host (.clk_in, .link_out(link_in));
  uoe_ctl u_uoe_ctl (.clk_in, .rstn_in, .ce_in, .bus_in, .link_in, .ep_done_in, .rdata_out, .rsp_out,
    .rsp_valid_out, .crc_check_out, .ep_enable_out);
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("FAIL %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    @(posedge clk_in) bus_in <= '{w, !w, a, d};
    @(posedge clk_in) bus_in <= '0;
    #1 if (!w) chk(rdata_out, e);
  endtask : bus
  task tok(input logic s, g, input logic [1:0] e);
    u_uoe_host.send(s, g);
    #1 chk(rsp_valid_out, !s);
    if (!s) chk(rsp_out, e);
  endtask : tok
  task final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task t_reset;
    bus(0, 12'hb00, 0, 32'h0000_8000);
    bus(1, 12'hb04, 32'hffff_ffff, 0);
    bus(0, 12'hb04, 0, 0);
    bus(0, 12'hb00, 0, 32'h0000_8000);
  endtask : t_reset
  task t_stall;
    bus(1, 12'hb00, 32'hffff_ffff, 0);
    bus(0, 12'hb00, 0, 32'h8032_8000);
    chk(crc_check_out, 0);
    tok(0, 0, UOE_RSP_STALL);
    tok(1, 0, 0);
    bus(0, 12'hb00, 0, 32'h8012_8000);
    tok(0, 0, UOE_RSP_NAK);
  endtask : t_stall
  task t_clear;
    bus(1, 12'hb00, 32'h0400_0000, 0);
    bus(0, 12'hb00, 0, 32'h8000_8000);
    chk(crc_check_out, 1);
    tok(0, 0, UOE_RSP_DATA);
    tok(0, 1, UOE_RSP_NAK);
    @(posedge clk_in) ep_done_in <= 1;
    @(posedge clk_in) ep_done_in <= 0;
    bus(0, 12'hb00, 0, 32'h0000_8000);
  endtask : t_clear
  task t_extra;
    u_uoe_host.set_mpl(2'h1);
    bus(0, 12'hb00, 0, 32'h0000_8001);
    @(posedge clk_in) ce_in <= 0;
    bus(1, 12'hb00, 32'h8800_0000, 0);
    @(posedge clk_in) ce_in <= 1;
    bus(0, 12'hb00, 0, 32'h0000_8001);
  endtask : t_extra
  initial forever #20 clk_in = ~clk_in;
  initial
  begin
    repeat (20) @(posedge clk_in);
    rstn_in <= 1;
    t_reset;
    t_stall;
    t_clear;
    t_extra;
    final_report;
  end
  initial
  begin
    #20us;
    fails++;
    final_report;
  end
endmodule : uoe_ctl_bench
bind uoe_ctl uoe_ctl_monitor u_uoe_ctl_monitor (.clk_in, .rstn_in, .ce_in, .bus_in, .link_in, .ep_done_in,
  .rdata_out, .rsp_out, .rsp_valid_out, .crc_check_out, .ep_enable_out);
`default_nettype wire
